// >>> dv/dshp_host_model.sv
// Host processor model that runs accesses on the host bus port pins.
module dshp_host_model (
    input  wire logic       mclk_i,
    input  wire logic       style_i,
    input  wire logic       shared_i,
    input  wire logic       ready_i,
    output logic            cs_n_o,
    output logic            rd_ds_n_o,
    output logic            wr_rw_o,
    output logic            ale_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_o    = 1'b1;
        rd_ds_n_o = 1'b1;
        wr_rw_o   = 1'b1;
        ale_o     = 1'b0;
        addr_o    = 8'h00;
        data_o    = 8'h00;
    end
    // =====================================================================
    // Access sequence.
    // Lines that are not carrying a value show the inverse of their last
    // value, so a design that samples too late sees garbage, not a match.
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output int waits);
        int n;
        n = 0;
        waits = 0;
        @(posedge mclk_i);
        if (shared_i) begin
            ale_o  <= 1'b1;
            data_o <= a;
            addr_o <= ~addr_o;
            repeat (3) @(posedge mclk_i);
            ale_o <= 1'b0;
            repeat (3) @(posedge mclk_i);
        end else begin
            addr_o <= a;
        end
        data_o    <= wr ? d : ~data_o;
        cs_n_o    <= 1'b0;
        rd_ds_n_o <= style_i ? 1'b0 : wr;
        wr_rw_o   <= ~wr;
        while (ready_i && n < 20) begin
            @(posedge mclk_i);
            n++;
        end
        while (!ready_i && n < 40) begin
            @(posedge mclk_i);
            n++;
            waits++;
        end
        cs_n_o    <= 1'b1;
        rd_ds_n_o <= 1'b1;
        wr_rw_o   <= 1'b1;
        data_o    <= ~data_o;
        addr_o    <= ~addr_o;
        repeat (4) @(posedge mclk_i);
    endtask : access
endmodule : dshp_host_model

// >>> dv/tb_dshp_host_bus_port.sv
// Self-checking bench for the host bus port driven by a host model.
`include "dshp_params.svh"
module tb_dshp_host_bus_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic         mclk_i, rst_i, style, shared, oe_prev, a;
    logic [159:0] meter;
    logic         cs_n, rd_ds_n, wr_rw, ale;
    logic [7:0]   addr, host_data, ad_o, tx_level_o, v, idx;
    logic         ad_oe_o, ready_o, ready_oe_o, irq_o, irq_oe_o;
    logic [15:0]  t;
    logic [31:0]  win;
    logic [7:0]   exp_q[$];
    int           bad_count, num_checks, seed;
    wire  [7:0]   ad_bus     = ad_oe_o ? ad_o : host_data;
    wire          ready_line = ~ready_oe_o;
    dshp_host_model host (
        .mclk_i(mclk_i), .style_i(style), .shared_i(shared),
        .ready_i(ready_line), .cs_n_o(cs_n), .rd_ds_n_o(rd_ds_n),
        .wr_rw_o(wr_rw), .ale_o(ale), .addr_o(addr), .data_o(host_data)
    );
    dshp_host_bus_port #(.TICK_DIV(16'h0002)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n), .rd_ds_n_i(rd_ds_n),
        .wr_rw_i(wr_rw), .ale_i(ale), .addr_i(addr), .ad_i(ad_bus),
        .bus_style_select_i(style), .shared_addr_data_select_i(shared),
        .meter_i(meter), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .ready_o(ready_o),
        .ready_oe_o(ready_oe_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o),
        .tx_level_o(tx_level_o)
    );
    // =====================================================================
    // Comparison and access tasks.
    task automatic chk_pin(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_pin
    task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
        chk_pin("read_data", e, g);
    endtask : chk_rd
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        int w;
        host.access(1'b1, ad, d, w);
        chk_pin("wait_states", {4'h0, `DSHP_WAIT_CYC}, 8'(w));
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        int w;
        exp_q.push_back(e);
        host.access(1'b0, ad, 8'h00, w);
        chk_pin("wait_states", {4'h0, `DSHP_WAIT_CYC}, 8'(w));
    endtask : rd
    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // =====================================================================
    // Clock, read watcher and watchdog.
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    always @(negedge mclk_i) begin
        if (ad_oe_o === 1'b1 && oe_prev !== 1'b1) begin
            chk_rd(exp_q.size() ? exp_q.pop_front() : 8'hXX, ad_o);
        end
        oe_prev = ad_oe_o;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        print_verdict();
    end
    // =====================================================================
    // Main sequence.
    initial begin
        rst_i <= 1'b1;
        style <= 1'b0;
        shared <= 1'b0;
        oe_prev = 1'b0;
        bad_count = 0;
        num_checks = 0;
        seed = 32'hac1784ab;
        for (int m = 0; m < 10; m++) meter[16*m+:16] <= $random(seed);
        repeat (16) @(posedge mclk_i);
        chk_pin("oe_reset", 8'h00, {5'h00, ad_oe_o, ready_oe_o, irq_oe_o});
        chk_pin("od_levels", 8'h00, {6'h00, ready_o, irq_o});
        chk_pin("tx_level_reset", `DSHP_TX_LVL_RST, tx_level_o);
        for (int md = 0; md < 4; md++) begin
            rst_i  <= 1'b1;
            style  <= md[0];
            shared <= md[1];
            repeat (3) @(posedge mclk_i);
            rst_i <= 1'b0;
            v = $random(seed);
            rd(`DSHP_OFS_TX_NOM, `DSHP_TX_NOM_DEF);
            wr(`DSHP_OFS_TX_LVL, v);
            wr(`DSHP_OFS_TX_NOM, ~v);
            wr(8'hA9, ~v);
            rd(`DSHP_OFS_TX_LVL, v);
            rd(`DSHP_OFS_TX_NOM, `DSHP_TX_NOM_DEF);
            rd(8'h00, 8'h00);
            chk_pin("tx_level", v, tx_level_o);
        end
        t = $random(seed);
        wr(8'h42, t[7:0]);
        wr(8'h43, t[15:8]);
        rd(8'h43, t[15:8]);
        rd(8'h42, t[7:0]);
        for (int i = 0; i < 12; i++) begin
            idx = (i == 0) ? 8'h01 : (i < 11) ? 8'(7 + i) : 8'h14;
            win = (i == 0) ? {16'h0000, t} : (i < 11) ?
                  {16'h0000, meter[16*(i-1)+:16]} : 32'h0000_0000;
            wr(`DSHP_OFS_IND_ADDR, idx);
            for (int k = 0; k < 4; k++) begin
                rd(`DSHP_OFS_WIN_BASE + 8'(k), win[8*k+:8]);
            end
        end
        wr(8'h40, 8'h02);
        wr(8'h41, 8'h00);
        wr(`DSHP_OFS_IRQ_MASK, 8'h00);
        wr(`DSHP_OFS_TMR_EN, 8'h01);
        repeat (40) @(posedge mclk_i);
        rd(`DSHP_OFS_TMR_STAT, 8'h01);
        a = irq_oe_o;
        wr(`DSHP_OFS_IRQ_MASK, 8'hFF);
        chk_pin("irq_mask", 8'h01, {7'h00, a ^ irq_oe_o});
        // A long preset must stop the short reload from expiring again.
        wr(`DSHP_OFS_WIN_BASE, 8'hFF);
        wr(`DSHP_OFS_WIN_BASE + 8'h01, 8'h7F);
        rd(`DSHP_OFS_WIN_BASE, 8'hFF);
        wr(`DSHP_OFS_IND_ADDR, 8'h80);
        rd(`DSHP_OFS_IND_ADDR, 8'h80);
        wr(`DSHP_OFS_TMR_STAT, 8'hFF);
        repeat (40) @(posedge mclk_i);
        rd(`DSHP_OFS_TMR_STAT, 8'h00);
        wr(`DSHP_OFS_TMR_EN, 8'h00);
        wr(`DSHP_OFS_TMR_STAT, 8'hFF);
        rd(`DSHP_OFS_TMR_STAT, 8'h00);
        chk_pin("irq_cleared", 8'h00, {7'h00, irq_oe_o});
        repeat (4) @(posedge mclk_i);
        chk_pin("reads_pending", 8'h00, 8'(exp_q.size()));
        chk_pin("od_levels", 8'h00, {6'h00, ready_o, irq_o});
        print_verdict();
    end
endmodule : tb_dshp_host_bus_port

// >>> rtl/dshp_host_bus_port.sv
// Host bus port: strobe decode, register map, timers and indirect window.
// Operation
// RULE_01 - Full 8-bit address decode over a 256-byte space.
// RULE_02 - Locations outside the direct map reached through index and window.
// RULE_03 - Style strap picks separate strobes or data strobe with direction.
// RULE_04 - Shared-bus strap picks latched multiplexed address or separate bus.
// RULE_05 - Multibyte values place the low byte at the lower address.
// RULE_06 - Ready is held low for wait states until the access completes.
// RULE_07 - Interrupt line asserted while an unmasked timer event is pending.
// RULE_08 - Eight 16-bit timers and ten meters controlled and read here.
// RULE_09 - Offset 0x28 returns the fixed factory nominal transmit gain.
// RULE_10 - Offset 0x29 holds the writable transmit level setting.
// RULE_11 - Style low uses read and write strobes, high uses data strobe.
// RULE_12 - Indirect data moves through window bytes 0x7C to 0x7F, byte 0 first.
`include "dshp_params.svh"
module dshp_host_bus_port #(
    parameter logic [7:0]  TX_NOMINAL = `DSHP_TX_NOM_DEF, // Arbitrary value.
    parameter logic [15:0] TICK_DIV   = `DSHP_TICK_DIV,
    parameter int          NUM_TMR    = 8,
    parameter int          NUM_MTR    = 10
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cs_n_i,
    input  wire logic                  rd_ds_n_i,
    input  wire logic                  wr_rw_i,
    input  wire logic                  ale_i,
    input  wire logic [7:0]            addr_i,
    input  wire logic [7:0]            ad_i,
    input  wire logic                  bus_style_select_i,
    input  wire logic                  shared_addr_data_select_i,
    input  wire logic [NUM_MTR*16-1:0] meter_i,
    output logic      [7:0]            ad_o,
    output logic                       ad_oe_o,
    output logic                       ready_o,
    output logic                       ready_oe_o,
    output logic                       irq_o,
    output logic                       irq_oe_o,
    output logic      [7:0]            tx_level_o
);
    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Host pins are asynchronous to the device clock, so everything is
    // resynchronised; the cost is a few cycles of ready latency.
    logic [21:0] pin_s1_q;
    logic [21:0] pin_s2_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            // Idle levels of the pins, so no false latch pulse follows reset.
            pin_s1_q <= `DSHP_PIN_IDLE;
            pin_s2_q <= `DSHP_PIN_IDLE;
        end else begin
            pin_s1_q <= {cs_n_i, rd_ds_n_i, wr_rw_i, ale_i, addr_i, ad_i,
                         bus_style_select_i, shared_addr_data_select_i};
            pin_s2_q <= pin_s1_q;
        end
    end
    wire       cs_n_s   = pin_s2_q[21];
    wire       rd_ds_s  = pin_s2_q[20];
    wire       wr_rw_s  = pin_s2_q[19];
    wire       ale_s    = pin_s2_q[18];
    wire [7:0] addr_s   = pin_s2_q[17:10];
    wire [7:0] ad_s     = pin_s2_q[9:2];
    wire       style_s  = pin_s2_q[1];
    wire       shared_s = pin_s2_q[0];

    // ==========================================================
    // Strobe decode and access sequencer
    // ==========================================================
    wire rd_act = style_s ? (!rd_ds_s && wr_rw_s) : !rd_ds_s; // [RULE_03] [RULE_11]
    wire wr_act = style_s ? (!rd_ds_s && !wr_rw_s) : !wr_rw_s; // [RULE_03] [RULE_11]
    wire acc    = !cs_n_s && (rd_act || wr_act);

    dshp_pkg::dshp_state_t st_q, st_d;
    logic [3:0] cnt_q;
    logic [7:0] a_q;
    logic [7:0] alat_q;
    logic       is_wr_q;
    wire  start  = (st_q == dshp_pkg::DSHP_IDLE) && acc && !ale_s;
    wire  commit = (st_q == dshp_pkg::DSHP_WAIT) && (cnt_q == 4'h1);
    wire  wr_cm  = commit && is_wr_q;
    wire  rd_cm  = commit && !is_wr_q;
    wire [7:0] a_sel = shared_s ? alat_q : addr_s; // [RULE_04]

    always_comb begin
        case (st_q)
            dshp_pkg::DSHP_IDLE: st_d = start ? dshp_pkg::DSHP_WAIT : st_q;
            dshp_pkg::DSHP_WAIT: st_d = commit ? dshp_pkg::DSHP_DONE : st_q;
            dshp_pkg::DSHP_DONE: st_d = acc ? st_q : dshp_pkg::DSHP_IDLE;
            default:             st_d = dshp_pkg::DSHP_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_q    <= dshp_pkg::DSHP_IDLE;
            cnt_q   <= 4'h0;
            a_q     <= 8'h00;
            alat_q  <= 8'h00;
            is_wr_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            alat_q <= ale_s ? ad_s : alat_q; // [RULE_04]
            if (start) begin
                cnt_q   <= `DSHP_WAIT_CYC;
                a_q     <= a_sel; // [RULE_01]
                is_wr_q <= wr_act;
            end else if (st_q == dshp_pkg::DSHP_WAIT) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    // ==========================================================
    // Register file
    // ==========================================================
    logic [7:0]  tx_lvl_q;
    logic [7:0]  tmr_en_q;
    logic [7:0]  stat_q;
    logic [7:0]  mask_q;
    logic [7:0]  ind_q;
    logic [7:0]  win_q [4];
    logic [15:0] tmr_ld_q  [NUM_TMR];
    logic [15:0] tmr_cnt_q [NUM_TMR];
    logic [15:0] tick_q;
    logic [7:0]  exp_ev;
    logic [15:0] item [32];

    wire        in_tmr  = (a_q & `DSHP_TMR_MASK) == `DSHP_OFS_TMR_BASE;
    wire        in_win  = (a_q & `DSHP_WIN_MASK) == `DSHP_OFS_WIN_BASE;
    wire        wr_ind  = wr_cm && (a_q == `DSHP_OFS_IND_ADDR);
    wire        ind_ld  = wr_ind && !ad_s[`DSHP_IND_WR_BIT];
    wire        ind_st  = wr_ind && ad_s[`DSHP_IND_WR_BIT];
    wire [15:0] ind_val = item[ad_s[4:0]];
    wire        tick    = (tick_q == 16'h0000);
    wire [15:0] tmr_sel = tmr_ld_q[a_q[3:1]];

    // Indirect items: timers first, then meters, the rest read zero.
    for (genvar k = 0; k < 32; k++) begin : g_item
        if (k < NUM_TMR) begin : g_t
            assign item[k] = tmr_cnt_q[k];
        end else if (k < NUM_TMR + NUM_MTR) begin : g_m
            assign item[k] = meter_i[(k-NUM_TMR)*16 +: 16]; // [RULE_08]
        end else begin : g_z
            assign item[k] = 16'h0000;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tx_lvl_q <= `DSHP_TX_LVL_RST;
            tmr_en_q <= 8'h00;
            stat_q   <= 8'h00;
            mask_q   <= 8'h00;
            ind_q    <= 8'h00;
            tick_q   <= 16'h0000;
        end else begin
            tick_q <= tick ? TICK_DIV - 16'h0001 : tick_q - 16'h0001;
            if (wr_cm && a_q == `DSHP_OFS_TX_LVL) begin
                tx_lvl_q <= ad_s; // [RULE_10]
            end
            if (wr_cm && a_q == `DSHP_OFS_TMR_EN) begin
                tmr_en_q <= ad_s;
            end
            if (wr_cm && a_q == `DSHP_OFS_IRQ_MASK) begin
                mask_q <= ad_s;
            end
            if (wr_ind) begin
                ind_q <= ad_s;
            end
            // A new event outranks a write-one clear in the same cycle.
            stat_q <= (stat_q & ~((wr_cm && a_q == `DSHP_OFS_TMR_STAT)
                      ? ad_s : 8'h00)) | exp_ev; // [RULE_08]
        end
    end

    // Window bytes: written by the host or filled by an indirect load.
    for (genvar w = 0; w < 4; w++) begin : g_win
        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                win_q[w] <= 8'h00;
            end else if (ind_ld) begin
                win_q[w] <= (w < 2) ? ind_val[w*8 +: 8] : 8'h00; // [RULE_12]
            end else if (wr_cm && in_win && a_q[1:0] == 2'(w)) begin
                win_q[w] <= ad_s; // [RULE_12]
            end
        end
    end

    // Down-counting timers; a stored window may preset a running count.
    for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
        wire hit = wr_cm && in_tmr && a_q[3:1] == 3'(t);
        assign exp_ev[t] = tmr_en_q[t] && tick && tmr_cnt_q[t] == 16'h0001;
        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                tmr_ld_q[t]  <= 16'h0000;
                tmr_cnt_q[t] <= 16'h0000;
            end else begin
                if (hit && !a_q[0]) begin
                    tmr_ld_q[t][7:0] <= ad_s; // [RULE_05]
                end
                if (hit && a_q[0]) begin
                    tmr_ld_q[t][15:8] <= ad_s; // [RULE_05]
                end
                if (ind_st && ad_s[4:0] == 5'(t)) begin
                    tmr_cnt_q[t] <= {win_q[1], win_q[0]}; // [RULE_02]
                end else if (!tmr_en_q[t]) begin
                    tmr_cnt_q[t] <= tmr_ld_q[t];
                end else if (tick) begin
                    tmr_cnt_q[t] <= (tmr_cnt_q[t] <= 16'h0001)
                                    ? tmr_ld_q[t]
                                    : tmr_cnt_q[t] - 16'h0001; // [RULE_08]
                end
            end
        end
    end

    // ==========================================================
    // Read data and pin drivers
    // ==========================================================
    // Unmapped addresses read zero so that every byte answers.
    wire [7:0] rd_data =
        (a_q == `DSHP_OFS_TX_NOM)   ? TX_NOMINAL :              // [RULE_09]
        (a_q == `DSHP_OFS_TX_LVL)   ? tx_lvl_q :
        in_tmr ? (a_q[0] ? tmr_sel[15:8] : tmr_sel[7:0]) :      // [RULE_05]
        (a_q == `DSHP_OFS_TMR_EN)   ? tmr_en_q :
        (a_q == `DSHP_OFS_TMR_STAT) ? stat_q :
        (a_q == `DSHP_OFS_IRQ_MASK) ? mask_q :
        (a_q == `DSHP_OFS_IND_ADDR) ? ind_q :
        in_win ? win_q[a_q[1:0]] : 8'h00;                       // [RULE_01]

    logic [7:0] ad_q;
    logic       ad_oe_q;
    logic       rdy_oe_q;
    logic       irq_oe_q;
    logic       low_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ad_q     <= 8'h00;
            ad_oe_q  <= 1'b0;
            rdy_oe_q <= 1'b0;
            irq_oe_q <= 1'b0;
            low_q    <= 1'b0;
        end else begin
            ad_q     <= rd_cm ? rd_data : ad_q;
            ad_oe_q  <= (rd_cm || ad_oe_q) && st_d != dshp_pkg::DSHP_IDLE;
            rdy_oe_q <= st_d == dshp_pkg::DSHP_WAIT; // [RULE_06]
            irq_oe_q <= |(stat_q & mask_q); // [RULE_07]
            low_q    <= 1'b0;
        end
    end
    assign ad_o       = ad_q;
    assign ad_oe_o    = ad_oe_q;
    assign ready_o    = low_q;
    assign ready_oe_o = rdy_oe_q;
    assign irq_o      = low_q;
    assign irq_oe_o   = irq_oe_q;
    assign tx_level_o = tx_lvl_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_wait2;
        rdy_oe_q [*2];
    endsequence
    property p_ready_wait;
        $rose(rdy_oe_q) |-> s_wait2 ##1 !rdy_oe_q;
    endproperty
    a_ready_wait: assert property (p_ready_wait) // [RULE_06]
        else $error("ready wait length wrong");

    property p_tx_lvl;
        wr_cm && a_q == `DSHP_OFS_TX_LVL |=> tx_lvl_q == $past(ad_s);
    endproperty
    a_tx_lvl: assert property (p_tx_lvl) // [RULE_10]
        else $error("transmit level not stored");

    property p_nom;
        rd_cm && a_q == `DSHP_OFS_TX_NOM |=> ad_q == TX_NOMINAL && ad_oe_q;
    endproperty
    a_nom: assert property (p_nom) // [RULE_09]
        else $error("nominal gain read wrong");

    property p_irq;
        (|(stat_q & mask_q)) |=> irq_oe_q;
    endproperty
    a_irq: assert property (p_irq) // [RULE_07]
        else $error("interrupt not raised");

    property p_set_wins;
        (|exp_ev) |=> (stat_q & $past(exp_ev)) == $past(exp_ev);
    endproperty
    a_set_wins: assert property (p_set_wins) // [RULE_08]
        else $error("timer event lost");

    property p_sep_strobe;
        st_q == dshp_pkg::DSHP_IDLE && !style_s && !cs_n_s && !rd_ds_s
        && wr_rw_s && !ale_s |=> st_q == dshp_pkg::DSHP_WAIT && !is_wr_q;
    endproperty
    a_sep_strobe: assert property (p_sep_strobe) // [RULE_11]
        else $error("separate strobe read not taken");

    property p_data_strobe;
        st_q == dshp_pkg::DSHP_IDLE && style_s && !cs_n_s && !rd_ds_s
        && !wr_rw_s && !ale_s |=> st_q == dshp_pkg::DSHP_WAIT && is_wr_q;
    endproperty
    a_data_strobe: assert property (p_data_strobe) // [RULE_03]
        else $error("data strobe write not taken");

    property p_mux_addr;
        start && shared_s |=> a_q == $past(alat_q);
    endproperty
    a_mux_addr: assert property (p_mux_addr) // [RULE_04]
        else $error("multiplexed address not used");

    property p_window;
        ind_ld |=> {win_q[1], win_q[0]} == $past(ind_val);
    endproperty
    a_window: assert property (p_window) // [RULE_12]
        else $error("window not loaded");

    property p_low_first;
        rd_cm && in_tmr && !a_q[0] |=> ad_q == $past(tmr_sel[7:0]);
    endproperty
    a_low_first: assert property (p_low_first) // [RULE_05]
        else $error("low byte not at even address");
endmodule : dshp_host_bus_port

// >>> rtl/dshp_params.svh
// Address map, reset values and timing counts of the host bus port.
`ifndef DSHP_PARAMS_SVH
`define DSHP_PARAMS_SVH
`define DSHP_OFS_TX_NOM   8'h28
`define DSHP_OFS_TX_LVL   8'h29
`define DSHP_OFS_TMR_BASE 8'h40
`define DSHP_TMR_MASK     8'hF0
`define DSHP_OFS_TMR_EN   8'h50
`define DSHP_OFS_TMR_STAT 8'h51
`define DSHP_OFS_IRQ_MASK 8'h52
`define DSHP_OFS_IND_ADDR 8'h7B
`define DSHP_OFS_WIN_BASE 8'h7C
`define DSHP_WIN_MASK     8'hFC
`define DSHP_IND_WR_BIT   7
`define DSHP_TX_LVL_RST   8'h00
`define DSHP_TX_NOM_DEF   8'h40
`define DSHP_WAIT_CYC     4'h2
`define DSHP_TICK_DIV     16'h0014
`define DSHP_PIN_IDLE     22'h380000
`endif

// >>> rtl/dshp_pkg.sv
// Types shared by the host bus port.
package dshp_pkg;
    typedef enum logic [1:0] {
        DSHP_IDLE = 2'b00,
        DSHP_WAIT = 2'b01,
        DSHP_DONE = 2'b10
    } dshp_state_t;
endpackage : dshp_pkg
